// file: hw/fvi_ctrl.sv
// Four-level vectored interrupt controller top
//
// Summary of operation
// - Fourteen sources, each placed on one of four priority levels.
// - Source requests only with flag, own enable and global enable set.
// - Software may write any request flag to one or zero.
// - Same-level simultaneous requests are granted in fixed source order.
// - Vector is 0003H plus eight times source number.
// - Each external input is level or edge activated by its own select bit.
// - Edge mode flag clears on vectoring; level mode flag follows input.
// - External flags sit in timer and external-interrupt control registers.
// - Timer A and B overflow flags clear in hardware on vectoring.
// - Serial request is receive-done OR transmit-done, cleared by software.
// - Timer C request is overflow OR external event, not hardware cleared.
// - SPI and conversion-done flags set by their engines, software cleared.
// - PCA request is counter overflow OR six module flags, software cleared.
// - System request ORs nine system flags, none hardware cleared.
// - Transmit-done joins system request only while redirect enable is set.
// - Start, stop and break-modulator flags feed the system request.
// - Keypad match flag requests, not cleared on vectoring.
// - Two-wire engine state flag requests, not cleared on vectoring.
// - Comparator edge flag requests, not cleared on vectoring.
// - Priority pair 11 highest, 10 second, 01 third, 00 lowest.
// - Global enable low blocks all; high lets each enable decide.
// - No preemption at equal or lower level; higher level wins first.
// - Sample each clock, poll next; block unfinished, return, config write.
`timescale 1ns/1ps
module fvi_ctrl
  import fvi_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  // External request pins and their mode bits
  input wire logic [NUM_EXT-1:0] ext_pin,
  input wire logic [NUM_EXT-1:0] ext_active_high,
  input wire logic [NUM_EXT-1:0] ext_req_edge_select,
  input wire logic tx_redirect_enable,
  // Peripheral set pulses, one per flag
  input wire logic [NUM_FLAG-1:0] flag_hw_set,
  // Software flag writes, per-bit strobe
  input wire logic [NUM_FLAG-1:0] flag_sw_wr,
  input wire logic [NUM_FLAG-1:0] flag_sw_data,
  // Configuration writes
  input wire logic global_wr,
  input wire logic global_wdata,
  input wire logic enable_wr,
  input wire logic [NUM_SRC-1:0] enable_wdata,
  input wire logic prio_wr,
  input wire logic [NUM_SRC-1:0] prio_high_wdata,
  input wire logic [NUM_SRC-1:0] prio_low_wdata,
  // Core side
  input wire logic core_last_cycle,
  input wire logic core_block_instr,
  input wire logic core_reti,
  output logic irq_call_q,
  output logic [VEC_W-1:0] irq_vector_q,
  output logic [SRC_W-1:0] irq_source_q,
  output logic [LVL_W-1:0] irq_level_q,
  // Status
  output logic [NUM_FLAG-1:0] flags_q,
  output logic global_irq_enable_q,
  output logic [NUM_SRC-1:0] src_enable_q,
  output logic [NUM_SRC-1:0] prio_high_q,
  output logic [NUM_SRC-1:0] prio_low_q,
  output logic [NUM_SRC-1:0] pending_q,
  output logic [NUM_LVL-1:0] in_service_q
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= RST_SYNC_RST;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_enable_q <= 1'b0;
    end else if (global_wr) begin
      global_irq_enable_q <= global_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_enable_q <= SRC_RST;
    end else if (enable_wr) begin
      src_enable_q <= enable_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prio_high_q <= SRC_RST;
      prio_low_q <= SRC_RST;
    end else if (prio_wr) begin
      prio_high_q <= prio_high_wdata;
      prio_low_q <= prio_low_wdata;
    end
  end

  // ----------------------------------------------------------------
  // External inputs
  // ----------------------------------------------------------------
  logic [NUM_EXT-1:0] ext_act;
  logic [NUM_EXT-1:0] ext_act_prev_q;
  logic [NUM_EXT-1:0] ext_edge;
  logic [NUM_EXT-1:0] ext_lvl_clr;

  // Low level or falling edge by default, inverted by ext_active_high
  assign ext_act = ext_pin ^ ~ext_active_high;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_act_prev_q <= '0;
    end else begin
      ext_act_prev_q <= ext_act;
    end
  end

  assign ext_edge = ext_act & ~ext_act_prev_q;
  // Level mode tracks the input both ways; edge mode only sets
  logic [NUM_EXT-1:0] ext_set_sel;
  always_comb begin
    for (int e = 0; e < NUM_EXT; e++) begin
      ext_set_sel[e] = ext_req_edge_select[e] ? ext_edge[e]
                                              : ext_act[e];
      ext_lvl_clr[e] = ~ext_req_edge_select[e] & ~ext_act[e];
    end
  end

  // ----------------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------------
  logic [NUM_FLAG-1:0] set_vec;
  logic [NUM_FLAG-1:0] clr_vec;
  logic [NUM_FLAG-1:0] vec_clr;

  always_comb begin
    set_vec = flag_hw_set;
    clr_vec = vec_clr;
    // External flags sit at fixed positions of their control registers
    set_vec[F_EXT0] = flag_hw_set[F_EXT0] | ext_set_sel[0];
    set_vec[F_EXT1] = flag_hw_set[F_EXT1] | ext_set_sel[1];
    set_vec[F_EXT2] = flag_hw_set[F_EXT2] | ext_set_sel[2];
    clr_vec[F_EXT0] = vec_clr[F_EXT0] | ext_lvl_clr[0];
    clr_vec[F_EXT1] = vec_clr[F_EXT1] | ext_lvl_clr[1];
    clr_vec[F_EXT2] = vec_clr[F_EXT2] | ext_lvl_clr[2];
  end

  genvar g;
  generate
    for (g = 0; g < NUM_FLAG; g++) begin : g_flag
      fvi_flag_cell u_cell (
        .clk(ref_clk),
        .rst_n(rst_n),
        .hw_set(set_vec[g]),
        .hw_clr(clr_vec[g]),
        .sw_wr(flag_sw_wr[g]),
        .sw_data(flag_sw_data[g]),
        .flag_q(flags_q[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Source requests
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] src_req;

  always_comb begin
    src_req = '0;
    src_req[S_EXT0] = flags_q[F_EXT0];
    src_req[S_TMRA] = flags_q[F_TMRA];
    src_req[S_EXT1] = flags_q[F_EXT1];
    src_req[S_TMRB] = flags_q[F_TMRB];
    src_req[S_SER] = flags_q[F_RX] | flags_q[F_TX];
    src_req[S_TMRC] = flags_q[F_TC_OVF] | flags_q[F_TC_EXT];
    src_req[S_EXT2] = flags_q[F_EXT2];
    src_req[S_SPI] = flags_q[F_SPI];
    src_req[S_CONV] = flags_q[F_CONV];
    src_req[S_PCA] = flags_q[F_PCA_CF]
      | (|flags_q[F_PCA_MOD +: PCA_MODS]);
    src_req[S_SYS] = (|flags_q[F_SYS_HI:F_SYS_LO])
      | (flags_q[F_TX] & tx_redirect_enable);
    src_req[S_KB] = flags_q[F_KB];
    src_req[S_TWI] = flags_q[F_TWI];
    src_req[S_AC] = flags_q[F_AC];
  end

  // Sampled this clock, polled on the next
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_q <= SRC_RST;
    end else begin
      pending_q <= src_req & src_enable_q
        & {NUM_SRC{global_irq_enable_q}};
    end
  end

  // ----------------------------------------------------------------
  // Level split and polling
  // ----------------------------------------------------------------
  logic [NUM_LVL-1:0] lvl_any;
  logic [SRC_W-1:0] lvl_idx [NUM_LVL];
  logic [NUM_SRC-1:0] lvl_req [NUM_LVL];

  generate
    for (g = 0; g < NUM_LVL; g++) begin : g_lvl
      localparam logic [LVL_W-1:0] LV = LVL_W'(g);
      // Pair {high,low} equal to the level number; 3 is highest
      assign lvl_req[g] = pending_q
        & ~(prio_high_q ^ {NUM_SRC{LV[LVL_W-1]}})
        & ~(prio_low_q ^ {NUM_SRC{LV[0]}});
      fvi_poll_arb #(
        .N(NUM_SRC),
        .W(SRC_W)
      ) u_arb (
        .req(lvl_req[g]),
        .any(lvl_any[g]),
        .idx(lvl_idx[g])
      );
    end
  endgenerate

  logic pick_any;
  logic [LVL_W-1:0] pick_lvl;
  logic [SRC_W-1:0] pick_idx;

  // Later, higher levels overwrite lower ones
  always_comb begin
    pick_any = 1'b0;
    pick_lvl = '0;
    pick_idx = '0;
    for (int l = 0; l < NUM_LVL; l++) begin
      if (lvl_any[l]) begin
        pick_any = 1'b1;
        pick_lvl = l[LVL_W-1:0];
        pick_idx = lvl_idx[l];
      end
    end
  end

  // ----------------------------------------------------------------
  // Grant decision
  // ----------------------------------------------------------------
  logic busy_ge;
  logic cfg_write;
  logic grant;

  assign busy_ge = |(in_service_q >> pick_lvl);
  // A write to enables or priorities counts as a blocking instruction
  assign cfg_write = global_wr | enable_wr | prio_wr;
  assign grant = pick_any & ~busy_ge & core_last_cycle
    & ~core_block_instr & ~cfg_write & ~core_reti;

  // Flags that hardware clears when their routine is entered
  always_comb begin
    vec_clr = '0;
    if (grant) begin
      if (pick_idx == SRC_W'(S_TMRA)) begin
        vec_clr[F_TMRA] = 1'b1;
      end
      if (pick_idx == SRC_W'(S_TMRB)) begin
        vec_clr[F_TMRB] = 1'b1;
      end
      if (pick_idx == SRC_W'(S_EXT0)) begin
        vec_clr[F_EXT0] = ext_req_edge_select[0];
      end
      if (pick_idx == SRC_W'(S_EXT1)) begin
        vec_clr[F_EXT1] = ext_req_edge_select[1];
      end
      if (pick_idx == SRC_W'(S_EXT2)) begin
        vec_clr[F_EXT2] = ext_req_edge_select[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // In-service levels
  // ----------------------------------------------------------------
  logic [NUM_LVL-1:0] reti_clr;

  // Return releases the highest level now in service
  always_comb begin
    reti_clr = '0;
    for (int l = 0; l < NUM_LVL; l++) begin
      if (in_service_q[l]) begin
        reti_clr = '0;
        reti_clr[l] = core_reti;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_service_q <= LVL_RST;
    end else if (grant) begin
      in_service_q[pick_lvl] <= 1'b1;
    end else begin
      in_service_q <= in_service_q & ~reti_clr;
    end
  end

  // ----------------------------------------------------------------
  // Call to the core
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_call_q <= 1'b0;
    end else begin
      irq_call_q <= grant;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_vector_q <= '0;
      irq_source_q <= '0;
      irq_level_q <= '0;
    end else if (grant) begin
      irq_vector_q <= VEC_BASE
        + VEC_W'(VEC_STEP * VEC_W'(pick_idx));
      irq_source_q <= pick_idx;
      irq_level_q <= pick_lvl;
    end
  end

endmodule // fvi_ctrl

// file: hw/fvi_pkg.sv
// Shared constants for the four-level vectored interrupt controller
package fvi_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 14;
  localparam int NUM_FLAG = 30;
  localparam int NUM_LVL = 4;
  localparam int NUM_EXT = 3;
  localparam int PCA_MODS = 6;
  localparam int SRC_W = 4;
  localparam int LVL_W = 2;
  localparam int VEC_W = 16;

  // ----------------------------------------------------------------
  // Flag positions in the flag vector
  // ----------------------------------------------------------------
  localparam int F_EXT0 = 0;
  localparam int F_TMRA = 1;
  localparam int F_EXT1 = 2;
  localparam int F_TMRB = 3;
  localparam int F_RX = 4;
  localparam int F_TX = 5;
  localparam int F_TC_OVF = 6;
  localparam int F_TC_EXT = 7;
  localparam int F_EXT2 = 8;
  localparam int F_SPI = 9;
  localparam int F_CONV = 10;
  localparam int F_PCA_CF = 11;
  localparam int F_PCA_MOD = 12;
  localparam int F_WDT = 18;
  localparam int F_BO_B = 19;
  localparam int F_BO_A = 20;
  localparam int F_RTC = 21;
  localparam int F_MCD = 22;
  localparam int F_STA = 23;
  localparam int F_STO = 24;
  localparam int F_BM_A = 25;
  localparam int F_BM_B = 26;
  localparam int F_KB = 27;
  localparam int F_TWI = 28;
  localparam int F_AC = 29;
  localparam int F_SYS_LO = F_WDT;
  localparam int F_SYS_HI = F_BM_B;

  // ----------------------------------------------------------------
  // Source numbers, also the polling order (0 polled first)
  // ----------------------------------------------------------------
  localparam int S_EXT0 = 0;
  localparam int S_TMRA = 1;
  localparam int S_EXT1 = 2;
  localparam int S_TMRB = 3;
  localparam int S_SER = 4;
  localparam int S_TMRC = 5;
  localparam int S_EXT2 = 6;
  localparam int S_SPI = 7;
  localparam int S_CONV = 8;
  localparam int S_PCA = 9;
  localparam int S_SYS = 10;
  localparam int S_KB = 11;
  localparam int S_TWI = 12;
  localparam int S_AC = 13;

  // ----------------------------------------------------------------
  // Vectors and reset values
  // ----------------------------------------------------------------
  localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;
  localparam logic [VEC_W-1:0] VEC_STEP = 16'h0008;
  localparam logic [NUM_SRC-1:0] SRC_RST = 14'h0000;
  localparam logic [NUM_LVL-1:0] LVL_RST = 4'h0;
  localparam logic [1:0] RST_SYNC_RST = 2'h0;

endpackage

// file: hw/fvi_flag_cell.sv
// One interrupt request flag: hardware set, software write, hardware clear
`timescale 1ns/1ps
module fvi_flag_cell (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hw_set,
  input wire logic hw_clr,
  input wire logic sw_wr,
  input wire logic sw_data,
  output logic flag_q
);

  // A hardware set in the same cycle as any clear or write still lands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (hw_set) begin
      flag_q <= 1'b1;
    end else if (sw_wr) begin
      flag_q <= sw_data;
    end else if (hw_clr) begin
      flag_q <= 1'b0;
    end
  end

endmodule // fvi_flag_cell

// file: hw/fvi_poll_arb.sv
// Fixed-order poll of one priority level: lowest request index wins
`timescale 1ns/1ps
module fvi_poll_arb #(
  parameter int N = 14,
  parameter int W = 4
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [W-1:0] idx
);

  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = i[W-1:0];
      end
    end
  end

endmodule // fvi_poll_arb

// file: verification/fvi_ctrl_properties.sv
// Port-level checks for the interrupt controller top
`timescale 1ns/1ps
module fvi_ctrl_chk
  import fvi_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [NUM_FLAG-1:0] flag_hw_set,
  input wire logic [NUM_FLAG-1:0] flag_sw_wr,
  input wire logic [NUM_FLAG-1:0] flag_sw_data,
  input wire logic global_wr,
  input wire logic enable_wr,
  input wire logic prio_wr,
  input wire logic core_last_cycle,
  input wire logic core_block_instr,
  input wire logic core_reti,
  input wire logic irq_call_q,
  input wire logic [VEC_W-1:0] irq_vector_q,
  input wire logic [SRC_W-1:0] irq_source_q,
  input wire logic [LVL_W-1:0] irq_level_q,
  input wire logic [NUM_FLAG-1:0] flags_q,
  input wire logic global_irq_enable_q,
  input wire logic [NUM_SRC-1:0] src_enable_q,
  input wire logic [NUM_SRC-1:0] prio_high_q,
  input wire logic [NUM_SRC-1:0] prio_low_q,
  input wire logic [NUM_LVL-1:0] in_service_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // Helpers: enables as the poll register saw them, return release
  // ------------------------------------------------------------
  logic [NUM_SRC-1:0] en_d1_q;
  logic [NUM_SRC-1:0] en_d2_q;
  logic [NUM_LVL-1:0] isv_d1_q;
  logic [NUM_LVL-1:0] isv_top_clr;
  always_ff @(posedge ref_clk) begin
    en_d1_q <= src_enable_q & {NUM_SRC{global_irq_enable_q}};
    en_d2_q <= en_d1_q;
    isv_d1_q <= in_service_q;
  end
  always_comb begin
    isv_top_clr = in_service_q;
    for (int i = 0; i < NUM_LVL; i++)
      if (in_service_q[i]) isv_top_clr = in_service_q & ~(4'h1 << i);
  end
  vector_map_a: assert property (
    irq_call_q |-> irq_vector_q == VEC_BASE + {irq_source_q, 3'h0})
    else $error("call vector does not match source");
  level_map_a: assert property (
    irq_call_q |-> irq_level_q ==
      {prio_high_q[irq_source_q], prio_low_q[irq_source_q]})
    else $error("call level does not match priority pair");
  enabled_src_a: assert property (
    irq_call_q |-> en_d2_q[irq_source_q])
    else $error("call for a disabled source");
  blocked_cycle_a: assert property (
    (!core_last_cycle || core_block_instr || core_reti || global_wr ||
     enable_wr || prio_wr) |=> !irq_call_q)
    else $error("call after a blocked poll cycle");
  no_preempt_a: assert property (
    irq_call_q |-> (isv_d1_q >> irq_level_q) == 4'h0)
    else $error("call at or below a level in service");
  service_mark_a: assert property (
    irq_call_q |-> in_service_q[irq_level_q])
    else $error("in-service bit not set by call");
  reti_release_a: assert property (
    core_reti |=> in_service_q == $past(isv_top_clr))
    else $error("return did not release the top level");
  timer_clear_a: assert property (
    irq_call_q && irq_source_q == S_TMRA && !$past(flag_hw_set[F_TMRA])
      |-> !flags_q[F_TMRA])
    else $error("timer flag kept after vectoring");
  serial_keep_a: assert property (
    irq_call_q && irq_source_q == S_SER && $past(flags_q[F_RX]) &&
      !$past(flag_sw_wr[F_RX]) |-> flags_q[F_RX])
    else $error("receive flag cleared by vectoring");
  sw_write_a: assert property (
    flag_sw_wr[F_KB] && !flag_hw_set[F_KB]
      |=> flags_q[F_KB] == $past(flag_sw_data[F_KB]))
    else $error("software flag write not taken");
endmodule // fvi_ctrl_chk

bind fvi_ctrl fvi_ctrl_chk u_chk (.*);

// file: verification/fvi_core_model.sv
// Behavioural processor core on the call side of the controller
`timescale 1ns/1ps
module fvi_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic irq_call,
  input wire logic stall,
  input wire logic block,
  input wire logic ret_go,
  output logic last_cycle,
  output logic block_instr,
  output logic reti
);
  int depth;
  assign last_cycle = !stall;
  assign block_instr = block;
  // A return only leaves a routine that was entered by a call
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      depth <= 0;
      reti <= 1'b0;
    end else begin
      reti <= ret_go && depth > 0;
      depth <= depth + int'(irq_call) - int'(ret_go && depth > 0);
    end
  end
endmodule // fvi_core_model

// file: verification/tb.sv
// Self-checking bench for the four-level interrupt controller
`timescale 1ns/1ps
module tb;
  import fvi_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0;
  logic [2:0] pin = 3'h0, edge_sel = 3'h7;
  logic redir = 1'b0, g_wr = 1'b0, g_d = 1'b0, e_wr = 1'b0, p_wr = 1'b0;
  logic [13:0] e_d = 14'h0000, ph = 14'h0000, pl = 14'h0000;
  logic [29:0] hw = 30'h00000000, sw = 30'h00000000;
  logic [29:0] swd = 30'h00000000, m;
  logic stall = 1'b0, blk = 1'b0, ret_go = 1'b0, seen;
  logic c_last, c_blk, c_reti, call, gq;
  logic [15:0] vec;
  logic [3:0] src, isv;
  logic [1:0] lvl;
  logic [29:0] flags;
  logic [13:0] enq, phq, plq, pend;
  int n_errors = 0, n_compared = 0;
  // ------------------------------------------------------------
  // Rows: flag raised, vector expected, flag kept after the call
  // ------------------------------------------------------------
  localparam int ROW_FLAG[14] = '{F_EXT0, F_TMRA, F_EXT1, F_TMRB, F_RX,
    F_TC_OVF, F_EXT2, F_SPI, F_CONV, F_PCA_MOD, F_WDT, F_KB, F_TWI, F_AC};
  localparam logic [15:0] ROW_VEC[14] = '{16'h0003, 16'h000B, 16'h0013,
    16'h001B, 16'h0023, 16'h002B, 16'h0033, 16'h003B, 16'h0043, 16'h004B,
    16'h0053, 16'h005B, 16'h0063, 16'h006B};
  localparam logic [13:0] ROW_KEEP = 14'h3FB0;

  initial forever #2 ref_clk = ~ref_clk;

  fvi_ctrl u_dut (.ref_clk(ref_clk), .resetn(resetn), .ext_pin(pin),
    .ext_active_high(3'h7), .ext_req_edge_select(edge_sel),
    .tx_redirect_enable(redir), .flag_hw_set(hw), .flag_sw_wr(sw),
    .flag_sw_data(swd), .global_wr(g_wr), .global_wdata(g_d),
    .enable_wr(e_wr), .enable_wdata(e_d), .prio_wr(p_wr),
    .prio_high_wdata(ph), .prio_low_wdata(pl), .core_last_cycle(c_last),
    .core_block_instr(c_blk), .core_reti(c_reti), .irq_call_q(call),
    .irq_vector_q(vec), .irq_source_q(src), .irq_level_q(lvl),
    .flags_q(flags), .global_irq_enable_q(gq), .src_enable_q(enq),
    .prio_high_q(phq), .prio_low_q(plq), .pending_q(pend),
    .in_service_q(isv));
  fvi_core_model u_core (.clk(ref_clk), .rst_n(resetn), .irq_call(call),
    .stall(stall), .block(blk), .ret_go(ret_go), .last_cycle(c_last),
    .block_instr(c_blk), .reti(c_reti));

  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task automatic cfg(logic g, logic [13:0] en, logic [13:0] h,
      logic [13:0] l);
    @(posedge ref_clk);
    g_wr <= 1'b1;
    g_d <= g;
    e_wr <= 1'b1;
    e_d <= en;
    p_wr <= 1'b1;
    ph <= h;
    pl <= l;
    @(posedge ref_clk);
    g_wr <= 1'b0;
    e_wr <= 1'b0;
    p_wr <= 1'b0;
  endtask
  // Peripheral set pulse when s is high, else a software write of d
  task automatic flag(logic [29:0] f, logic s, logic d);
    @(posedge ref_clk);
    if (s) hw <= f;
    else begin
      sw <= f;
      swd <= {30{d}};
    end
    @(posedge ref_clk);
    hw <= '0;
    sw <= '0;
  endtask
  // No trailing wait: a call queued behind the released level comes
  // two edges later and the next wait_call must still see it
  task automatic ret();
    @(posedge ref_clk);
    ret_go <= 1'b1;
    @(posedge ref_clk);
    ret_go <= 1'b0;
  endtask
  task automatic wait_call(int lim);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(negedge ref_clk);
      seen = (call === 1'b1);
    end
  endtask
  task automatic quiet(int n);
    repeat (n) begin
      @(negedge ref_clk);
      chk("no call", 0, call);
    end
    @(posedge ref_clk);
  endtask
  // Takes a call, clears its flag by software, returns when r is high
  task automatic serve(int s, logic [1:0] l, int f, logic r);
    wait_call(20);
    chk("call", {1'b1, 4'(s)}, {seen, src});
    chk("vector", ROW_VEC[s], vec);
    chk("level", l, lvl);
    chk("in service", 1, isv[l]);
    chk("flag kept", ROW_KEEP[s], flags[f]);
    flag(30'h1 << f, 1'b0, 1'b0);
    if (r) ret();
  endtask
  task automatic give_verdict();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("reset state", 0, {call, gq, enq, phq, plq, pend, isv});
    chk("reset flags", 0, flags);
    cfg(1'b1, 14'h3FFF, 14'h0000, 14'h0000);
    for (int i = 0; i < NUM_SRC; i++) begin
      flag(30'h1 << ROW_FLAG[i], 1'b1, 1'b0);
      serve(i, 2'h0, ROW_FLAG[i], 1'b1);
    end
    m = '0;
    foreach (ROW_FLAG[i]) m[ROW_FLAG[i]] = 1'b1;
    flag(m, 1'b0, 1'b1);
    for (int i = 0; i < NUM_SRC; i++) serve(i, 2'h0, ROW_FLAG[i], 1'b1);
    cfg(1'b1, 14'h3FFF, 14'h2002, 14'h2004);
    flag(30'h20000007, 1'b1, 1'b0);
    serve(13, 2'h3, F_AC, 1'b0);
    quiet(8);
    ret();
    serve(1, 2'h2, F_TMRA, 1'b1);
    serve(2, 2'h1, F_EXT1, 1'b1);
    serve(0, 2'h0, F_EXT0, 1'b0);
    flag(30'h1 << F_AC, 1'b1, 1'b0);
    serve(13, 2'h3, F_AC, 1'b1);
    ret();
    cfg(1'b0, 14'h3FFF, 14'h0000, 14'h0000);
    flag(30'h1 << F_SPI, 1'b1, 1'b0);
    quiet(10);
    cfg(1'b1, 14'h3F7F, 14'h0000, 14'h0000);
    quiet(10);
    cfg(1'b1, 14'h3FFF, 14'h0000, 14'h0000);
    serve(7, 2'h0, F_SPI, 1'b1);
    blk <= 1'b1;
    flag(30'h1 << F_CONV, 1'b1, 1'b0);
    quiet(10);
    blk <= 1'b0;
    stall <= 1'b1;
    quiet(10);
    stall <= 1'b0;
    serve(8, 2'h0, F_CONV, 1'b1);
    cfg(1'b1, 14'h0400, 14'h0000, 14'h0000);
    flag(30'h1 << F_TX, 1'b1, 1'b0);
    quiet(10);
    redir <= 1'b1;
    serve(10, 2'h0, F_TX, 1'b1);
    redir <= 1'b0;
    cfg(1'b1, 14'h3FFF, 14'h0000, 14'h0000);
    edge_sel <= 3'h0;
    pin <= 3'h1;
    wait_call(20);
    chk("level call", 5'h10, {seen, src});
    chk("level flag", 1, flags[F_EXT0]);
    @(posedge ref_clk);
    pin <= 3'h0;
    repeat (6) @(negedge ref_clk);
    chk("level flag off", 0, flags[F_EXT0]);
    ret();
    edge_sel <= 3'h7;
    pin <= 3'h4;
    serve(6, 2'h0, F_EXT2, 1'b1);
    pin <= 3'h0;
    give_verdict();
  end
endmodule // tb
